// [logic/mwc_pkg.sv]
// shared constants and carrier types of the mac wake-up and checksum control block
// assumes a single 200 MHz clock and an apb master with 32-bit data
package mwc_pkg;
   // clock period in picoseconds, used to turn times into cycles
   localparam int CLK_PERIOD_PS = 5000;
   // register indices as printed, byte address is four times the index
   localparam logic [7:0] WAKE_CSR_IDX = 8'h0c;
   localparam logic [7:0] CHECKSUM_OFFLOAD_CONTROL_IDX = 8'h0d;
   localparam logic [7:0] WAKE_CSR_ADDR = 8'(WAKE_CSR_IDX * 4);
   localparam logic [7:0] CHECKSUM_OFFLOAD_CONTROL_ADDR = 8'(CHECKSUM_OFFLOAD_CONTROL_IDX * 4);
   // interrupt status, mask and indirect phy access
   localparam logic [7:0] INT_STAT_ADDR = 8'h10;
   localparam logic [7:0] INT_MASK_ADDR = 8'h14;
   localparam logic [7:0] PHY_ACC_ADDR = 8'h18;
   localparam logic [7:0] PHY_DATA_ADDR = 8'h1c;
   // wake control and status fields
   localparam int WK_GUE_BIT = 9;
   localparam int WK_WAKE_FRAME_RECEIVED_BIT = 6;
   localparam int WK_MPR_BIT = 5;
   localparam int WK_WAKE_FRAME_DETECT_ENABLE_BIT = 2;
   localparam int WK_MAGIC_PACKET_DETECT_ENABLE_BIT = 1;
   // checksum offload fields
   localparam int COE_TX_EN_BIT = 16;
   localparam int COE_RX_MODE_BIT = 1;
   localparam int COE_RX_EN_BIT = 0;
   // checksum start offset in default mode, bytes
   localparam logic [4:0] RX_CSUM_DEFAULT_START = 5'h0e;
   // phy access fields: index low, write flag, busy flag
   localparam int PHY_ACC_WR_BIT = 8;
   localparam int PHY_ACC_BUSY_BIT = 31;
   // reset value of every apb-mapped block register
   localparam logic [31:0] REG_RESET = 32'h00000000;
   // interrupt status bit positions
   localparam int IRQ_WAKE_FRAME_RECEIVED = 0;
   localparam int IRQ_MPR = 1;
   localparam int IRQ_WAKE = 2;
   localparam int IRQ_W = 3;
   // phy register indices
   localparam logic [4:0] PHY_BCR = 5'h00;
   localparam logic [4:0] PHY_BSR = 5'h01;
   localparam logic [4:0] PHY_ID1 = 5'h02;
   localparam logic [4:0] PHY_ID2 = 5'h03;
   localparam logic [4:0] PHY_AN_ADV = 5'h04;
   localparam logic [4:0] PHY_AN_LPA = 5'h05;
   localparam logic [4:0] PHY_AN_EXP = 5'h06;
   localparam logic [4:0] PHY_MODE = 5'h11;
   localparam logic [4:0] PHY_SPMODE = 5'h12;
   localparam logic [4:0] PHY_SPIND = 5'h1b;
   localparam logic [4:0] PHY_ISRC = 5'h1d;
   localparam logic [4:0] PHY_IMASK = 5'h1e;
   localparam logic [4:0] PHY_SPCTL = 5'h1f;
   // basic control fields and reset values
   localparam int PHY_RST_BIT = 15;
   localparam logic [15:0] PHY_BCR_WMASK = 16'h7980;
   localparam logic [15:0] PHY_BCR_RESET = 16'h1000;
   localparam logic [15:0] PHY_BSR_VALUE = 16'h7809;
   // phy software reset duration
   localparam int PHY_RST_NS = 100;
   localparam int PHY_RST_CYC = (PHY_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // one received frame as seen by the wake logic
   typedef struct packed {
      logic done;
      logic da_bit0;
      logic wake_match;
      logic magic;
   } mwc_rx_event_s;
   // wake enables handed to the detector
   typedef struct packed {
      logic power_save;
      logic global_unicast_wake_enable;
      logic wake_frame_detect_enable;
      logic magic_packet_detect_enable;
   } mwc_wake_cfg_s;
endpackage

// [logic/mwc_wake_detect.sv]
// wake-up event detector: turns frame results into status pulses
// assumes frame results come from receive logic on the same clock
`timescale 1ns/1ps
module mwc_wake_detect (
   input wire mwc_pkg::mwc_rx_event_s ev_in,
   input wire mwc_pkg::mwc_wake_cfg_s cfg_in,
   output logic set_wake_frame_received_out,
   output logic set_mpr_out,
   output logic wake_out
);
   // filter match only counts in remote wake-up mode
   always_comb
   begin
      set_wake_frame_received_out = ev_in.done & ev_in.wake_match & cfg_in.wake_frame_detect_enable;
      set_mpr_out = ev_in.done & ev_in.magic & cfg_in.magic_packet_detect_enable;
      // leave power saving only while in it
      wake_out = cfg_in.power_save & (set_wake_frame_received_out | set_mpr_out
         | (ev_in.done & ~ev_in.da_bit0 & cfg_in.global_unicast_wake_enable));
   end
endmodule

// [logic/mwc_phy_regs.sv]
// phy register bank reached only by index, never by bus address
// assumes one index access per cycle from the management access logic
`timescale 1ns/1ps
module mwc_phy_regs #(
   parameter logic [15:0] ID1 = 16'h1234, // arbitrary value
   parameter logic [15:0] ID2 = 16'h5678 // arbitrary value
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic wr_en_in,
   input wire logic [4:0] idx_in,
   input wire logic [15:0] wdata_in,
   output logic [15:0] rdata_out,
   output logic busy_out
);
   // writable bits per index; unmapped indices take nothing
   function automatic logic [15:0] wr_mask(input logic [4:0] idx);
      unique case (idx)
         mwc_pkg::PHY_BCR: wr_mask = mwc_pkg::PHY_BCR_WMASK;
         mwc_pkg::PHY_AN_ADV, mwc_pkg::PHY_MODE, mwc_pkg::PHY_SPMODE,
         mwc_pkg::PHY_SPIND, mwc_pkg::PHY_IMASK, mwc_pkg::PHY_SPCTL: wr_mask = 16'hffff;
         default: wr_mask = 16'h0000;
      endcase
   endfunction
   // reset value per index
   function automatic logic [15:0] rst_val(input logic [4:0] idx);
      unique case (idx)
         mwc_pkg::PHY_BCR: rst_val = mwc_pkg::PHY_BCR_RESET;
         mwc_pkg::PHY_BSR: rst_val = mwc_pkg::PHY_BSR_VALUE;
         mwc_pkg::PHY_ID1: rst_val = ID1;
         mwc_pkg::PHY_ID2: rst_val = ID2;
         default: rst_val = 16'h0000;
      endcase
   endfunction
   logic [15:0] phy_mem [0:31]; // one word per index
   logic [7:0] rst_cnt_r; // soft reset countdown
   // soft reset timer, started by bit 15 of basic control
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         rst_cnt_r <= 8'h00;
      else if (wr_en_in && idx_in == mwc_pkg::PHY_BCR && wdata_in[mwc_pkg::PHY_RST_BIT])
         rst_cnt_r <= 8'(mwc_pkg::PHY_RST_CYC);
      else if (rst_cnt_r != 8'h00)
         rst_cnt_r <= rst_cnt_r - 8'h01;
   end
   // register words; soft reset spares the immune special modes word
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         for (int i = 0; i < 32; i++)
            phy_mem[i] <= rst_val(5'(i));
      end
      else if (rst_cnt_r == 8'h01)
      begin
         for (int i = 0; i < 32; i++)
            if (5'(i) != mwc_pkg::PHY_SPMODE)
               phy_mem[i] <= rst_val(5'(i));
      end
      else if (wr_en_in)
         phy_mem[idx_in] <= (phy_mem[idx_in] & ~wr_mask(idx_in)) | (wdata_in & wr_mask(idx_in));
   end
   // reset bit reads back high until the reset completes
   always_comb
   begin
      busy_out = rst_cnt_r != 8'h00;
      rdata_out = phy_mem[idx_in];
      if (idx_in == mwc_pkg::PHY_BCR)
         rdata_out[mwc_pkg::PHY_RST_BIT] = busy_out;
   end
endmodule

// [logic/mwc_top.sv]
// mac wake-up and checksum offload control registers with indirect phy access
// assumes an apb master on mclk_in and receive logic on the same clock
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module mwc_top #(
   parameter logic [15:0] PHY_ID1 = 16'h1234, // arbitrary value
   parameter logic [15:0] PHY_ID2 = 16'h5678 // arbitrary value
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire mwc_pkg::mwc_rx_event_s rx_event_in,
   input wire logic power_save_in,
   output logic wake_out,
   output logic tx_csum_en_out,
   output logic rx_csum_en_out,
   output logic rx_csum_l3_start_out,
   output logic [4:0] rx_csum_start_out,
   output logic irq_out
);
   // wake control and status fields
   logic gue_r; // unicast wake enable
   logic wake_frame_detect_enable_r; // wake frame detect enable
   logic magic_packet_detect_enable_r; // magic packet detect enable
   logic wake_frame_received_r; // wake frame received flag
   logic mpr_r; // magic packet received flag
   // interrupt state
   logic [mwc_pkg::IRQ_W-1:0] int_stat_r;
   logic [mwc_pkg::IRQ_W-1:0] int_mask_r;
   // indirect phy access state
   logic [4:0] phy_idx_r; // last index used
   logic phy_wr_r; // last access was a write
   logic [15:0] phy_data_r; // management data word
   // apb answer staging
   logic [31:0] rdata_nxt;
   logic addr_ok_nxt;
   // phy bank interface
   logic phy_wr_en;
   logic [4:0] phy_idx;
   logic [15:0] phy_rdata;
   logic phy_busy;
   // detector outputs
   logic set_wake_frame_received;
   logic set_mpr;
   logic wake_pulse;
   mwc_pkg::mwc_wake_cfg_s wake_cfg;
   // write access phase that completes this edge
   logic acc_wr;
   // decode address of a mapped register
   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = a == mwc_pkg::WAKE_CSR_ADDR || a == mwc_pkg::CHECKSUM_OFFLOAD_CONTROL_ADDR
         || a == mwc_pkg::INT_STAT_ADDR || a == mwc_pkg::INT_MASK_ADDR
         || a == mwc_pkg::PHY_ACC_ADDR || a == mwc_pkg::PHY_DATA_ADDR;
   endfunction
   // write access to a given address completing now
   function automatic logic wr_hit(input logic [7:0] a, input logic w, input logic [7:0] target);
      wr_hit = w && a == target;
   endfunction
   assign acc_wr = psel_in & penable_in & pready_out & pwrite_in;
   // wake detector sees live enables
   always_comb
   begin
      wake_cfg.power_save = power_save_in;
      wake_cfg.global_unicast_wake_enable = gue_r;
      wake_cfg.wake_frame_detect_enable = wake_frame_detect_enable_r;
      wake_cfg.magic_packet_detect_enable = magic_packet_detect_enable_r;
   end
   mwc_wake_detect u_wake (
      .ev_in(rx_event_in),
      .cfg_in(wake_cfg),
      .set_wake_frame_received_out(set_wake_frame_received),
      .set_mpr_out(set_mpr),
      .wake_out(wake_pulse)
   );
   // phy index comes from the access word being written
   assign phy_idx = wr_hit(paddr_in, acc_wr, mwc_pkg::PHY_ACC_ADDR) ? pwdata_in[4:0] : phy_idx_r;
   assign phy_wr_en = wr_hit(paddr_in, acc_wr, mwc_pkg::PHY_ACC_ADDR)
      & pwdata_in[mwc_pkg::PHY_ACC_WR_BIT];
   mwc_phy_regs #(
      .ID1(PHY_ID1),
      .ID2(PHY_ID2)
   ) u_phy (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .wr_en_in(phy_wr_en),
      .idx_in(phy_idx),
      .wdata_in(phy_data_r),
      .rdata_out(phy_rdata),
      .busy_out(phy_busy)
   );
   // read mux; reserved bits stay zero
   always_comb
   begin
      rdata_nxt = mwc_pkg::REG_RESET;
      addr_ok_nxt = addr_mapped(paddr_in);
      unique case (paddr_in)
         mwc_pkg::WAKE_CSR_ADDR:
         begin
            rdata_nxt[mwc_pkg::WK_GUE_BIT] = gue_r;
            rdata_nxt[mwc_pkg::WK_WAKE_FRAME_RECEIVED_BIT] = wake_frame_received_r;
            rdata_nxt[mwc_pkg::WK_MPR_BIT] = mpr_r;
            rdata_nxt[mwc_pkg::WK_WAKE_FRAME_DETECT_ENABLE_BIT] = wake_frame_detect_enable_r;
            rdata_nxt[mwc_pkg::WK_MAGIC_PACKET_DETECT_ENABLE_BIT] = magic_packet_detect_enable_r;
         end
         mwc_pkg::CHECKSUM_OFFLOAD_CONTROL_ADDR:
         begin
            rdata_nxt[mwc_pkg::COE_TX_EN_BIT] = tx_csum_en_out;
            rdata_nxt[mwc_pkg::COE_RX_MODE_BIT] = rx_csum_l3_start_out;
            rdata_nxt[mwc_pkg::COE_RX_EN_BIT] = rx_csum_en_out;
         end
         mwc_pkg::INT_STAT_ADDR: rdata_nxt[mwc_pkg::IRQ_W-1:0] = int_stat_r;
         mwc_pkg::INT_MASK_ADDR: rdata_nxt[mwc_pkg::IRQ_W-1:0] = int_mask_r;
         mwc_pkg::PHY_ACC_ADDR:
         begin
            rdata_nxt[4:0] = phy_idx_r;
            rdata_nxt[mwc_pkg::PHY_ACC_WR_BIT] = phy_wr_r;
            rdata_nxt[mwc_pkg::PHY_ACC_BUSY_BIT] = phy_busy;
         end
         mwc_pkg::PHY_DATA_ADDR: rdata_nxt[15:0] = phy_data_r;
         default: rdata_nxt = mwc_pkg::REG_RESET; // unmapped reads zero
      endcase
   end
   // apb answer: ready one cycle after setup, data sampled at setup
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         pready_out <= 1'b0;
         prdata_out <= mwc_pkg::REG_RESET;
         pslverr_out <= 1'b0;
      end
      else
      begin
         pready_out <= psel_in & ~penable_in;
         // unmapped addresses answer with an error and zero data
         if (psel_in && !penable_in)
         begin
            prdata_out <= pwrite_in ? mwc_pkg::REG_RESET : rdata_nxt;
            pslverr_out <= ~addr_ok_nxt;
         end
         else
            pslverr_out <= 1'b0;
      end
   end
   // wake enables, written as a whole word
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         gue_r <= 1'b0;
         wake_frame_detect_enable_r <= 1'b0;
         magic_packet_detect_enable_r <= 1'b0;
      end
      else if (wr_hit(paddr_in, acc_wr, mwc_pkg::WAKE_CSR_ADDR))
      begin
         gue_r <= pwdata_in[mwc_pkg::WK_GUE_BIT];
         wake_frame_detect_enable_r <= pwdata_in[mwc_pkg::WK_WAKE_FRAME_DETECT_ENABLE_BIT];
         magic_packet_detect_enable_r <= pwdata_in[mwc_pkg::WK_MAGIC_PACKET_DETECT_ENABLE_BIT];
      end
   end
   // received flags: write one clears, a new event in the same cycle wins
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         wake_frame_received_r <= 1'b0;
         mpr_r <= 1'b0;
      end
      else
      begin
         if (set_wake_frame_received)
            wake_frame_received_r <= 1'b1;
         else if (wr_hit(paddr_in, acc_wr, mwc_pkg::WAKE_CSR_ADDR) && pwdata_in[mwc_pkg::WK_WAKE_FRAME_RECEIVED_BIT])
            wake_frame_received_r <= 1'b0;
         if (set_mpr)
            mpr_r <= 1'b1;
         else if (wr_hit(paddr_in, acc_wr, mwc_pkg::WAKE_CSR_ADDR) && pwdata_in[mwc_pkg::WK_MPR_BIT])
            mpr_r <= 1'b0;
      end
   end
   // checksum engine controls; software keeps them steady while paths run
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         tx_csum_en_out <= 1'b0;
         rx_csum_l3_start_out <= 1'b0;
         rx_csum_en_out <= 1'b0;
      end
      else if (wr_hit(paddr_in, acc_wr, mwc_pkg::CHECKSUM_OFFLOAD_CONTROL_ADDR))
      begin
         tx_csum_en_out <= pwdata_in[mwc_pkg::COE_TX_EN_BIT];
         rx_csum_l3_start_out <= pwdata_in[mwc_pkg::COE_RX_MODE_BIT];
         rx_csum_en_out <= pwdata_in[mwc_pkg::COE_RX_EN_BIT];
      end
   end
   // start offset for the receive engine; zero means find layer 3 itself
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         rx_csum_start_out <= mwc_pkg::RX_CSUM_DEFAULT_START;
      else if (wr_hit(paddr_in, acc_wr, mwc_pkg::CHECKSUM_OFFLOAD_CONTROL_ADDR))
         rx_csum_start_out <= pwdata_in[mwc_pkg::COE_RX_MODE_BIT] ? 5'h00
            : mwc_pkg::RX_CSUM_DEFAULT_START;
   end
   // wake output, one cycle per waking frame
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         wake_out <= 1'b0;
      else
         wake_out <= wake_pulse;
   end
   // interrupt status: set wins over write-one clear
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         int_stat_r <= '0;
      else
      begin
         for (int i = 0; i < mwc_pkg::IRQ_W; i++)
         begin
            if ((i == mwc_pkg::IRQ_WAKE_FRAME_RECEIVED && set_wake_frame_received) || (i == mwc_pkg::IRQ_MPR && set_mpr)
                || (i == mwc_pkg::IRQ_WAKE && wake_pulse))
               int_stat_r[i] <= 1'b1;
            else if (wr_hit(paddr_in, acc_wr, mwc_pkg::INT_STAT_ADDR) && pwdata_in[i])
               int_stat_r[i] <= 1'b0;
         end
      end
   end
   // interrupt mask
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         int_mask_r <= '0;
      else if (wr_hit(paddr_in, acc_wr, mwc_pkg::INT_MASK_ADDR))
         int_mask_r <= pwdata_in[mwc_pkg::IRQ_W-1:0];
   end
   // level interrupt, one cycle behind status
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         irq_out <= 1'b0;
      else
         irq_out <= |(int_stat_r & int_mask_r);
   end
   // indirect phy access: a read copies the indexed word into the data word
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         phy_idx_r <= 5'h00;
         phy_wr_r <= 1'b0;
         phy_data_r <= 16'h0000;
      end
      else if (wr_hit(paddr_in, acc_wr, mwc_pkg::PHY_ACC_ADDR))
      begin
         phy_idx_r <= pwdata_in[4:0];
         phy_wr_r <= pwdata_in[mwc_pkg::PHY_ACC_WR_BIT];
         if (!pwdata_in[mwc_pkg::PHY_ACC_WR_BIT])
            phy_data_r <= phy_rdata;
      end
      else if (wr_hit(paddr_in, acc_wr, mwc_pkg::PHY_DATA_ADDR))
         phy_data_r <= pwdata_in[15:0];
   end
   // checks
   localparam int RST_BOUND = mwc_pkg::PHY_RST_CYC + 2;
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);
   apb_ready_a: assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
      else $error("ready not one cycle after setup");
   wake_frame_received_set_a: assert property (set_wake_frame_received |=> wake_frame_received_r && int_stat_r[mwc_pkg::IRQ_WAKE_FRAME_RECEIVED])
      else $error("wake frame flag not set");
   mpr_set_a: assert property (rx_event_in.done && rx_event_in.magic && magic_packet_detect_enable_r |=> mpr_r)
      else $error("magic flag not set");
   magic_packet_detect_enable_gate_a: assert property (!magic_packet_detect_enable_r && !mpr_r && !acc_wr |=> !mpr_r)
      else $error("magic flag set while disabled");
   wake_frame_detect_enable_gate_a: assert property (!wake_frame_detect_enable_r |-> !set_wake_frame_received)
      else $error("wake frame seen while disabled");
   gue_wake_a: assert property (power_save_in && gue_r && rx_event_in.done && !rx_event_in.da_bit0
      |=> wake_out)
      else $error("unicast frame did not wake");
   tx_coe_a: assert property (wr_hit(paddr_in, acc_wr, mwc_pkg::CHECKSUM_OFFLOAD_CONTROL_ADDR)
      |=> tx_csum_en_out == $past(pwdata_in[mwc_pkg::COE_TX_EN_BIT]))
      else $error("tx checksum enable wrong");
   rx_coe_a: assert property (wr_hit(paddr_in, acc_wr, mwc_pkg::CHECKSUM_OFFLOAD_CONTROL_ADDR)
      |=> rx_csum_en_out == $past(pwdata_in[0]) && rx_csum_l3_start_out == $past(pwdata_in[1]))
      else $error("rx checksum control wrong");
   rx_start_a: assert property (!rx_csum_l3_start_out |-> rx_csum_start_out == 5'h0e)
      else $error("default start is not 14 bytes");
   reset_zero_a: assert property ($past(rst_in) |-> !gue_r && !wake_frame_received_r && !mpr_r && !tx_csum_en_out
      && !rx_csum_en_out)
      else $error("registers not zero after reset");
   flag_sticky_a: assert property (wake_frame_received_r && !acc_wr |=> wake_frame_received_r)
      else $error("wake frame flag dropped");
   irq_level_a: assert property (##1 irq_out == $past(|(int_stat_r & int_mask_r)))
      else $error("interrupt level wrong");
   phy_rst_done_a: assert property ($rose(phy_busy) |-> ##[1:RST_BOUND] !phy_busy)
      else $error("phy reset bit did not clear");
   wake_cv: cover property (wake_out);
   magic_clear_cv: cover property (mpr_r ##[1:20] !mpr_r);
   phy_read_cv: cover property (wr_hit(paddr_in, acc_wr, mwc_pkg::PHY_ACC_ADDR) && !phy_wr_en);
   irq_cv: cover property (irq_out);
endmodule

// [sim/tb_mwc_top.sv]
// self-checking bench for the wake-up and checksum control block
// assumes one-cycle apb answers; bench drives frame results itself
`timescale 1ns/1ps
module tb_mwc_top;
   logic mclk_in = 1'b0; // 200 MHz
   logic rst_in = 1'b1; // synchronous, active high
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h00000000;
   logic [31:0] prdata_out;
   logic pready_out;
   logic pslverr_out;
   mwc_pkg::mwc_rx_event_s rx_event_in = '0; // frame result
   logic power_save_in = 1'b0;
   logic wake_out;
   logic tx_csum_en_out;
   logic rx_csum_en_out;
   logic rx_csum_l3_start_out;
   logic [4:0] rx_csum_start_out;
   logic irq_out;
   int n_errors = 0;
   int samples_checked = 0;
   int cyc = 0; // hang guard
   logic [31:0] rd; // last read word
   logic err; // last slave error

   mwc_top u_mwc_top (.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .rx_event_in(rx_event_in),
      .power_save_in(power_save_in), .wake_out(wake_out), .tx_csum_en_out(tx_csum_en_out),
      .rx_csum_en_out(rx_csum_en_out), .rx_csum_l3_start_out(rx_csum_l3_start_out),
      .rx_csum_start_out(rx_csum_start_out), .irq_out(irq_out));

   // free-running clock
   always #2.5 mclk_in = ~mclk_in;

   // counts and verdict, the only way out
   task automatic print_verdict();
      begin
         $display("checks %0d errors %0d", samples_checked, n_errors);
         if (n_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask

   // whole run is well under this many cycles
   always @(posedge mclk_in)
   begin
      cyc++;
      if (cyc >= 20000)
      begin
         n_errors++;
         print_verdict();
      end
   end

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         samples_checked++;
         if (got !== exp)
         begin
            n_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask

   // one apb transfer; request held until pready is sampled high at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      begin
         n = 0;
         @(posedge mclk_in);
         psel_in <= 1'b1;
         pwrite_in <= wr;
         paddr_in <= a;
         pwdata_in <= wd;
         @(posedge mclk_in);
         penable_in <= 1'b1;
         @(posedge mclk_in);
         // pready, read data and error are taken at the completing edge
         while (pready_out !== 1'b1 && n < 20)
         begin
            @(posedge mclk_in);
            n++;
         end
         if (n >= 20)
            chk(32'h00000001, 32'h00000000);
         rd = prdata_out;
         err = pslverr_out;
         psel_in <= 1'b0;
         penable_in <= 1'b0;
      end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      begin
         apb(1'b0, a, 32'h00000000);
         chk(rd, exp);
      end
   endtask

   // one frame result, then the one-cycle wake pulse
   task automatic frame(input logic da0, input logic wm, input logic mg, input logic ew);
      begin
         @(posedge mclk_in);
         rx_event_in <= {1'b1, da0, wm, mg};
         @(posedge mclk_in);
         rx_event_in <= '0;
         #1;
         chk({31'h0, wake_out}, {31'h0, ew});
         @(posedge mclk_in);
         #1;
         chk({31'h0, wake_out}, 32'h00000000);
      end
   endtask

   // indirect phy access through the access and data words
   task automatic phy_wr(input logic [4:0] i, input logic [15:0] d);
      begin
         apb(1'b1, mwc_pkg::PHY_DATA_ADDR, {16'h0, d});
         apb(1'b1, mwc_pkg::PHY_ACC_ADDR, {23'h0, 1'b1, 3'h0, i});
      end
   endtask

   task automatic phy_rd(input logic [4:0] i, input logic [15:0] e);
      begin
         apb(1'b1, mwc_pkg::PHY_ACC_ADDR, {27'h0, i});
         apb(1'b0, mwc_pkg::PHY_DATA_ADDR, 32'h00000000);
         chk({16'h0, rd[15:0]}, {16'h0, e});
      end
   endtask

   // reset values and checksum controls
   task automatic t_regs();
      begin
         rdc(mwc_pkg::WAKE_CSR_ADDR, 32'h00000000);
         rdc(mwc_pkg::CHECKSUM_OFFLOAD_CONTROL_ADDR, 32'h00000000);
         chk({24'h0, tx_csum_en_out, rx_csum_en_out, rx_csum_l3_start_out, rx_csum_start_out}, 32'h0000000e);
         // no data path runs in this bench, so enables and mode change while idle
         apb(1'b1, mwc_pkg::CHECKSUM_OFFLOAD_CONTROL_ADDR, 32'hffffffff);
         rdc(mwc_pkg::CHECKSUM_OFFLOAD_CONTROL_ADDR, 32'h00010003);
         chk({24'h0, tx_csum_en_out, rx_csum_en_out, rx_csum_l3_start_out, rx_csum_start_out}, 32'h000000e0);
         apb(1'b1, mwc_pkg::CHECKSUM_OFFLOAD_CONTROL_ADDR, 32'h00000001);
         #1;
         chk({24'h0, tx_csum_en_out, rx_csum_en_out, rx_csum_l3_start_out, rx_csum_start_out}, 32'h0000004e);
         apb(1'b1, mwc_pkg::CHECKSUM_OFFLOAD_CONTROL_ADDR, 32'h00010000);
         #1;
         chk({24'h0, tx_csum_en_out, rx_csum_en_out, rx_csum_l3_start_out, rx_csum_start_out}, 32'h0000008e);
         apb(1'b1, mwc_pkg::WAKE_CSR_ADDR, 32'hffffffff);
         rdc(mwc_pkg::WAKE_CSR_ADDR, 32'h00000206);
      end
   endtask

   // wake sources, enables and sticky flags
   task automatic t_wake();
      begin
         power_save_in <= 1'b1;
         frame(1'b1, 1'b0, 1'b1, 1'b1);
         rdc(mwc_pkg::WAKE_CSR_ADDR, 32'h00000226);
         frame(1'b1, 1'b1, 1'b0, 1'b1);
         rdc(mwc_pkg::WAKE_CSR_ADDR, 32'h00000266);
         apb(1'b1, mwc_pkg::WAKE_CSR_ADDR, 32'h00000266);
         rdc(mwc_pkg::WAKE_CSR_ADDR, 32'h00000206);
         frame(1'b0, 1'b0, 1'b0, 1'b1);
         frame(1'b1, 1'b0, 1'b0, 1'b0);
         apb(1'b1, mwc_pkg::WAKE_CSR_ADDR, 32'h00000000);
         frame(1'b1, 1'b1, 1'b1, 1'b0);
         frame(1'b0, 1'b0, 1'b0, 1'b0);
         rdc(mwc_pkg::WAKE_CSR_ADDR, 32'h00000000);
         apb(1'b1, mwc_pkg::WAKE_CSR_ADDR, 32'h00000206);
         power_save_in <= 1'b0;
         frame(1'b1, 1'b0, 1'b1, 1'b0);
         rdc(mwc_pkg::WAKE_CSR_ADDR, 32'h00000226);
      end
   endtask

   // interrupt raised, masked and cleared
   task automatic t_irq();
      begin
         apb(1'b1, mwc_pkg::INT_STAT_ADDR, 32'h00000007);
         rdc(mwc_pkg::INT_STAT_ADDR, 32'h00000000);
         apb(1'b1, mwc_pkg::INT_MASK_ADDR, 32'h00000002);
         chk({31'h0, irq_out}, 32'h00000000);
         frame(1'b1, 1'b0, 1'b1, 1'b0);
         rdc(mwc_pkg::INT_STAT_ADDR, 32'h00000002);
         chk({31'h0, irq_out}, 32'h00000001);
         apb(1'b1, mwc_pkg::INT_MASK_ADDR, 32'h00000000);
         rdc(mwc_pkg::INT_MASK_ADDR, 32'h00000000);
         chk({31'h0, irq_out}, 32'h00000000);
         apb(1'b1, mwc_pkg::INT_MASK_ADDR, 32'h00000002);
         apb(1'b1, mwc_pkg::INT_STAT_ADDR, 32'h00000002);
         rdc(mwc_pkg::INT_STAT_ADDR, 32'h00000000);
         chk({31'h0, irq_out}, 32'h00000000);
      end
   endtask

   // unmapped words refused; phy reached only by index
   task automatic t_phy();
      begin
         apb(1'b0, 8'h40, 32'h00000000);
         chk({err, rd[30:0]}, 32'h80000000);
         apb(1'b1, 8'h3c, 32'hffffffff);
         chk({31'h0, err}, 32'h00000001);
         phy_rd(mwc_pkg::PHY_BSR, mwc_pkg::PHY_BSR_VALUE);
         phy_rd(mwc_pkg::PHY_ID1, 16'h1234);
         phy_rd(5'h07, 16'h0000);
         phy_wr(mwc_pkg::PHY_AN_ADV, 16'h0de1);
         phy_rd(mwc_pkg::PHY_AN_ADV, 16'h0de1);
         phy_wr(mwc_pkg::PHY_SPMODE, 16'h00a5);
         phy_wr(mwc_pkg::PHY_BCR, 16'h8000);
         apb(1'b0, mwc_pkg::PHY_ACC_ADDR, 32'h00000000);
         chk({31'h0, rd[31]}, 32'h00000001);
         repeat (mwc_pkg::PHY_RST_CYC + 5) @(posedge mclk_in);
         apb(1'b0, mwc_pkg::PHY_ACC_ADDR, 32'h00000000);
         chk({31'h0, rd[31]}, 32'h00000000);
         phy_rd(mwc_pkg::PHY_BCR, mwc_pkg::PHY_BCR_RESET);
         phy_rd(mwc_pkg::PHY_SPMODE, 16'h00a5);
      end
   endtask

   // main sequence
   initial
   begin
      repeat (4) @(posedge mclk_in);
      rst_in <= 1'b0;
      t_regs();
      t_wake();
      t_irq();
      t_phy();
      print_verdict();
   end
endmodule
